// ### rtl/jfc_cmd.sv
`timescale 1ns/100ps
module jfc_cmd
  import jfc_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // virtual chain from the hub, test clock domain
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic [IR_W-1:0] ir_in_i,
  input wire logic vs_cdr_i,
  input wire logic vs_sdr_i,
  input wire logic vs_udr_i,
  input wire logic vs_uir_i,
  output logic tdo_o,
  // drained words
  output logic [DW-1:0] data_o,
  output logic data_valid_o,
  // status
  output logic fifo_empty_o,
  output logic flush_busy_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    jfc_lnk_s sy1;
    jfc_lnk_s sy2;
    jfc_lnk_s prv;
    logic [DW-1:0] in_chain;
    logic [DW-1:0] out_chain;
    logic [DW-1:0] wr_word;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] dout;
    logic byp;
    logic tdo;
    logic wr_pend;
    logic rd_pend;
    logic flush;
    logic dvalid;
  } jfc_st_s;

  jfc_st_s r_reg;
  jfc_st_s r_next;
  jfc_lnk_s lnk_raw;
  jfc_cmd_e cmd_prv;
  jfc_cmd_e cmd_cur;
  logic tck_rise;
  logic udr_push;
  logic uir_fall;
  logic uir_pop;
  logic uir_flush;
  logic rd_fire;

  jfc_fifo_if #(.W(DW)) f ();

  // refuse widths the chains are not built for
  if (DW < 1 || DW > 64) begin : g_bad_width
    $error("data width out of range");
  end

  // ****************************************
  // word store, on the block clock only
  // ****************************************
  // the test clock never reaches the store; all link pins are sampled
  jfc_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .st(f.store)
  );

  // ****************************************
  // link sampling and events
  // ****************************************
  assign lnk_raw = '{tck: tck_i, tdi: tdi_i, cdr: vs_cdr_i, sdr: vs_sdr_i, udr: vs_udr_i,
                     uir: vs_uir_i, ir: ir_in_i};
  // one decoder for both fifo sides
  assign cmd_prv = jfc_decode(r_reg.prv.ir);
  assign cmd_cur = jfc_decode(r_reg.sy2.ir);
  // states are taken from the sample before the edge, so a state that moves
  // with the same tck edge cannot be mistaken for the new one
  assign tck_rise = r_reg.sy2.tck && !r_reg.prv.tck;
  assign udr_push = r_reg.sy2.udr && !r_reg.prv.udr && cmd_cur == CMD_PUSH;
  assign uir_fall = !r_reg.sy2.uir && r_reg.prv.uir;
  assign uir_pop = uir_fall && cmd_cur == CMD_POP;
  assign uir_flush = uir_fall && cmd_cur == CMD_FLUSH;

  // fifo handshakes; unknown codes leave both ports idle
  assign f.in_valid = r_reg.wr_pend;
  assign f.in_data = r_reg.wr_word;
  assign f.out_ready = r_reg.rd_pend || r_reg.flush;
  assign rd_fire = f.out_valid && f.out_ready;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    // first stage feeds only the second
    r_next.sy1 = lnk_raw;
    r_next.sy2 = r_reg.sy1;
    r_next.prv = r_reg.sy2;
    // chain work on each test clock rise
    if (tck_rise) begin
      if (r_reg.prv.cdr && cmd_prv == CMD_POP) begin
        r_next.out_chain = r_reg.rd_word;
      end
      if (r_reg.prv.sdr) begin
        unique case (cmd_prv)
          CMD_PUSH: r_next.in_chain = {r_reg.prv.tdi, r_reg.in_chain[DW-1:1]};
          CMD_POP: r_next.out_chain = {r_reg.prv.tdi, r_reg.out_chain[DW-1:1]};
          CMD_FLUSH: r_next.byp = r_reg.prv.tdi;
          CMD_BYP: r_next.byp = r_reg.prv.tdi;
        endcase
      end
    end
    // output bit follows the selected chain
    unique case (cmd_cur)
      CMD_PUSH: r_next.tdo = r_reg.in_chain[0];
      CMD_POP: r_next.tdo = r_reg.out_chain[0];
      CMD_FLUSH: r_next.tdo = r_reg.byp;
      CMD_BYP: r_next.tdo = r_reg.byp;
    endcase
    // a write waits while the store is full; a later update replaces a word still waiting
    if (f.in_ready) begin
      r_next.wr_pend = 1'b0;
    end
    if (udr_push) begin
      r_next.wr_pend = 1'b1;
      r_next.wr_word = r_reg.in_chain;
    end
    // single read pulse; a read of an empty store keeps the old word
    r_next.rd_pend = uir_pop;
    r_next.dvalid = 1'b0;
    if (rd_fire) begin
      r_next.rd_word = f.out_data;
      r_next.dout = f.out_data;
      r_next.dvalid = 1'b1;
    end
    // burst until empty; a new flush wins over the end of the old one
    if (r_reg.flush && !f.out_valid) begin
      r_next.flush = 1'b0;
    end
    if (uir_flush) begin
      r_next.flush = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign tdo_o = r_reg.tdo;
  assign data_o = r_reg.dout;
  assign data_valid_o = r_reg.dvalid;
  assign fifo_empty_o = !f.out_valid;
  assign flush_busy_o = r_reg.flush;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_pop_pulse;
    r_reg.rd_pend ##1 !r_reg.rd_pend;
  endsequence

  property p_push_shift;
    tck_rise && r_reg.prv.sdr && cmd_prv == CMD_PUSH
      |=> r_reg.in_chain == {$past(r_reg.prv.tdi), $past(r_reg.in_chain[DW-1:1])};
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push chain not shifted");

  property p_wr_req;
    udr_push |=> r_reg.wr_pend && r_reg.wr_word == $past(r_reg.in_chain);
  endproperty
  a_wr_req: assert property (p_wr_req) else $error("no write after update");

  property p_wr_once;
    f.in_valid && f.in_ready && !udr_push |=> !f.in_valid;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("write pulse repeated");

  property p_pop_once;
    uir_pop |=> s_pop_pulse;
  endproperty
  a_pop_once: assert property (p_pop_once) else $error("read pulse not single");

  property p_capture;
    tck_rise && r_reg.prv.cdr && cmd_prv == CMD_POP |=> r_reg.out_chain == $past(r_reg.rd_word);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_out_shift;
    tck_rise && r_reg.prv.sdr && cmd_prv == CMD_POP
      |=> r_reg.out_chain[DW-2:0] == $past(r_reg.out_chain[DW-1:1]) ##1 tdo_o == r_reg.out_chain[0]
        || cmd_cur != CMD_POP;
  endproperty
  a_out_shift: assert property (p_out_shift) else $error("read chain not shifted");

  property p_flush_hold;
    r_reg.flush && f.out_valid |=> r_reg.flush && f.out_ready;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush dropped early");

  property p_bypass;
    tck_rise && r_reg.prv.sdr && (cmd_prv == CMD_FLUSH || cmd_prv == CMD_BYP)
      |=> r_reg.byp == $past(r_reg.prv.tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not loaded");

  property p_idle_code;
    cmd_cur == CMD_BYP && !r_reg.flush && !r_reg.rd_pend && !r_reg.wr_pend
      |=> (!f.in_valid && !f.out_ready) [*2];
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("port active on unknown code");

endmodule : jfc_cmd

// ### inc/jfc_pkg.sv
package jfc_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int IR_W = 3;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int REF_CLK_NS = 40;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [IR_W-1:0] IR_PUSH = 3'h1;
  localparam logic [IR_W-1:0] IR_POP = 3'h2;
  localparam logic [IR_W-1:0] IR_FLUSH = 3'h3;

  typedef enum logic [1:0] {CMD_BYP, CMD_PUSH, CMD_POP, CMD_FLUSH} jfc_cmd_e;

  // link pins as sampled by the block clock
  typedef struct packed {
    logic tck;
    logic tdi;
    logic cdr;
    logic sdr;
    logic udr;
    logic uir;
    logic [IR_W-1:0] ir;
  } jfc_lnk_s;

  // command decode shared by every place that looks at the instruction
  function automatic jfc_cmd_e jfc_decode(input logic [IR_W-1:0] code);
    unique case (code)
      IR_PUSH: jfc_decode = CMD_PUSH;
      IR_POP: jfc_decode = CMD_POP;
      IR_FLUSH: jfc_decode = CMD_FLUSH;
      default: jfc_decode = CMD_BYP;
    endcase
  endfunction : jfc_decode

endpackage : jfc_pkg

// ### inc/jfc_fifo_if.sv
`timescale 1ns/100ps
// fill and drain handshakes between the decoder and the word store
interface jfc_fifo_if #(
  parameter int W = 8
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface : jfc_fifo_if

// ### rtl/jfc_fifo.sv
`timescale 1ns/100ps
module jfc_fifo
  import jfc_pkg::*;
#(
  parameter int W = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // both handshakes
  jfc_fifo_if.store st
);

  localparam int AW = $clog2(DEPTH);

  // pointers carry one extra bit so full and empty are told apart
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } jfc_fst_s;

  jfc_fst_s r_reg;
  jfc_fst_s r_next;
  logic full;
  logic empty;

  // refuse sizes the pointer arithmetic cannot serve, before anything runs
  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_bad_size
    $error("depth must be a power of two of at least two");
  end

  // ****************************************
  // status and handshakes
  // ****************************************
  assign empty = (r_reg.wp == r_reg.rp);
  assign full = (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]) && (r_reg.wp[AW] != r_reg.rp[AW]);
  assign st.in_ready = !full;
  assign st.out_valid = !empty;
  assign st.out_data = r_reg.mem[r_reg.rp[AW-1:0]];

  // next pointers and storage
  always_comb begin
    r_next = r_reg;
    if (st.in_valid && !full) begin
      r_next.mem[r_reg.wp[AW-1:0]] = st.in_data;
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (st.out_ready && !empty) begin
      r_next.rp = r_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : jfc_fifo

// ### dv/jfc_hub_model.sv
`timescale 1ns/100ps
// ****
// host and hub side of the virtual chain
// ****
module jfc_hub_model
  import jfc_pkg::*;
(
  // link toward the node
  output logic tck_o,
  output logic tdi_o,
  output logic [IR_W-1:0] ir_o,
  output logic cdr_o,
  output logic sdr_o,
  output logic udr_o,
  output logic uir_o,
  // answer
  input wire logic tdo_i
);
  // test clock stands low outside frames
  initial begin
    {tck_o, tdi_o, ir_o, cdr_o, sdr_o, udr_o, uir_o} = '0;
  end
  // one test clock; both halves end on block-clock falling edges
  task automatic tick(output logic s);
    #160;
    s = tdo_i;
    tck_o = 1'b1;
    #160;
    tck_o = 1'b0;
  endtask : tick
  // instruction load, taken at the fall of update-instruction
  task automatic ir_shift(input logic [IR_W-1:0] code);
    logic s;
    ir_o = code;
    uir_o = 1'b1;
    tick(s);
    uir_o = 1'b0;
    tick(s);
  endtask : ir_shift
  // capture, eight shifts lsb first, then update
  task automatic dr_shift(input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd);
    logic s;
    cdr_o = 1'b1;
    tick(s);
    cdr_o = 1'b0;
    sdr_o = 1'b1;
    for (int k = 0; k < DATA_W; k++) begin
      tdi_o = wd[k];
      tick(rd[k]);
    end
    sdr_o = 1'b0;
    tdi_o = ~tdi_o; // released line must not look held
    udr_o = 1'b1;
    tick(s);
    udr_o = 1'b0;
    tick(s);
  endtask : dr_shift
endmodule : jfc_hub_model

// ### dv/tb_jtag_fifo_command_access.sv
`timescale 1ns/100ps
module tb_jtag_fifo_command_access;
  import jfc_pkg::*;
  logic ref_clk_i, rst_i, tck, tdi, cdr, sdr, udr, uir, tdo;
  logic data_valid_o, fifo_empty_o, flush_busy_o;
  logic [IR_W-1:0] ir;
  logic [DATA_W-1:0] data_o, rd, w;
  logic [DATA_W-1:0] exp_q[$];
  logic [DATA_W-1:0] got_q[$];
  int miscompares, tests_run, seed, busy_seen;

  // ****
  // clock, parts
  // ****
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  jfc_cmd i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .tck_i(tck), .tdi_i(tdi),
    .ir_in_i(ir), .vs_cdr_i(cdr), .vs_sdr_i(sdr), .vs_udr_i(udr), .vs_uir_i(uir),
    .tdo_o(tdo), .data_o(data_o), .data_valid_o(data_valid_o),
    .fifo_empty_o(fifo_empty_o), .flush_busy_o(flush_busy_o));
  jfc_hub_model i_hub (.tck_o(tck), .tdi_o(tdi), .ir_o(ir), .cdr_o(cdr), .sdr_o(sdr),
    .udr_o(udr), .uir_o(uir), .tdo_i(tdo));
  // collect every word the store gives up, away from the launching edge
  always @(negedge ref_clk_i) begin
    if (data_valid_o === 1'b1) got_q.push_back(data_o);
    if (flush_busy_o === 1'b1) busy_seen++;
  end

  // ****
  // checking
  // ****
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bypass answers each bit one shift late, so bit 0 is stale
  function automatic logic [7:0] exp_bypass(input logic [7:0] wd);
    exp_bypass = {wd[6:0], 1'b0};
  endfunction : exp_bypass
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // whole run needs about 100 us; allow ten times that
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end

  // ****
  // scenarios
  // ****
  initial begin
    seed = 58;
    rst_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk("empty_at_reset", 8'h01, {7'h0, fifo_empty_o});
    // flush of an empty store moves nothing
    i_hub.ir_shift(IR_FLUSH);
    repeat (20) @(negedge ref_clk_i);
    chk("empty_flush_words", 8'h00, 8'(got_q.size()));
    // fill all places with random words
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      w = 8'($random(seed));
      // corner words: all ones leads, all zeros closes
      if (i == 0) w = 8'hff;
      if (i == FIFO_DEPTH - 1) w = 8'h00;
      exp_q.push_back(w);
      i_hub.ir_shift(IR_PUSH);
      i_hub.dr_shift(w, rd);
    end
    repeat (10) @(negedge ref_clk_i);
    chk("empty_when_full", 8'h00, {7'h0, fifo_empty_o});
    // single read, then the captured word shifted back out
    i_hub.ir_shift(IR_POP);
    i_hub.dr_shift(8'h00, rd);
    chk("pop_count", 8'h01, 8'(got_q.size()));
    chk("pop_word", exp_q[0], got_q[0]);
    chk("pop_shift", exp_q[0], rd);
    // burst drain, order kept
    busy_seen = 0;
    i_hub.ir_shift(IR_FLUSH);
    for (int t = 0; t < 200 && got_q.size() < FIFO_DEPTH; t++) @(negedge ref_clk_i);
    repeat (4) @(negedge ref_clk_i);
    chk("flush_count", 8'(FIFO_DEPTH), 8'(got_q.size()));
    for (int i = 1; i < FIFO_DEPTH; i++) chk("flush_word", exp_q[i], got_q[i]);
    chk("flush_busy", 8'h01, 8'(busy_seen >= FIFO_DEPTH - 1));
    chk("flush_done", 8'h02, {6'h0, fifo_empty_o, flush_busy_o});
    // flush and unknown codes: one-bit bypass, store left alone
    for (int c = 3; c < 9; c++) begin
      w = 8'($random(seed));
      i_hub.ir_shift(3'(c));
      i_hub.dr_shift(w, rd);
      chk("bypass", exp_bypass(w), {rd[7:1], 1'b0});
    end
    // read of an empty store gives nothing
    i_hub.ir_shift(IR_POP);
    repeat (20) @(negedge ref_clk_i);
    chk("idle_count", 8'(FIFO_DEPTH), 8'(got_q.size()));
    tally_and_finish();
  end
endmodule : tb_jtag_fifo_command_access
